// File: bus_fault_pkg.sv
// Constants and types shared by the bus fault status block
package bus_fault_pkg;

  // ==========================================================
  // Register word indices (byte address is four times these)
  localparam logic [7:0] CTRL_IDX = 8'h40;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h41;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h42;
  localparam logic [7:0] BUS_FAULT_STATUS_IDX = 8'h43;

  // ==========================================================
  // Status field positions
  localparam int unsigned STATUS_W = 16;
  localparam int unsigned LIN_FAULT_LSB = 5;
  localparam int unsigned CAN_TIMEOUT_BIT = 4;
  localparam int unsigned SELWAKE_SYSTEM_ERROR_BIT = 3;
  localparam int unsigned CAN_FAULT_LSB = 1;
  localparam int unsigned SUPPLY_LOW_BIT = 0;
  localparam int unsigned SELWAKE_CTRL_BIT = 0;

  // Fault codes of both two-bit fields
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_TSD = 2'h1;
  localparam logic [1:0] FAULT_TXD_DOM = 2'h2;
  localparam logic [1:0] FAULT_BUS_DOM = 2'h3;

  // Error counter limit, flag sets when exceeded
  localparam logic [5:0] SELWAKE_ERR_LIMIT = 6'h20;

  // ==========================================================
  // Interrupt status / mask layout
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_CAN_TIMEOUT = 0;
  localparam int unsigned IRQ_SELWAKE_SYSTEM_ERROR = 1;
  localparam int unsigned IRQ_SUPPLY_LOW = 2;
  localparam int unsigned IRQ_CAN_FAULT = 3;
  localparam int unsigned IRQ_LIN_FAULT = 4;

  // Reset values
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TX_ENABLE_NS = 10000;
  localparam int unsigned TX_ENABLE_CYCLES =
    (TX_ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Transceiver mode
  typedef enum logic [1:0] {
    XCVR_OFF = 2'h0,
    XCVR_WAKE = 2'h1,
    XCVR_RX_ONLY = 2'h2,
    XCVR_NORMAL = 2'h3
  } xcvr_mode_type;

  // Transmitter recovery states
  typedef enum logic [2:0] {
    TX_RUN = 3'h1,
    TX_FAULT = 3'h2,
    TX_ARM = 3'h4
  } tx_state_type;

endpackage

// File: tx_recovery.sv
// Transmitter fault recovery and enable-time wait for one transceiver
`timescale 1ns/10ps
module tx_recovery #(
  parameter int unsigned ENABLE_CYCLES = bus_fault_pkg::TX_ENABLE_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic soft_reset,
  // Fault levels
  input wire logic fault_tsd,
  input wire logic fault_txd_dom,
  input wire logic fault_bus_dom,
  input wire logic fault_supply,
  // Line and mode
  input wire logic txd,
  input wire logic bus_recessive,
  input wire bus_fault_pkg::xcvr_mode_type xcvr_mode,
  // Result
  output logic tx_enable
);
  import bus_fault_pkg::*;

  localparam int unsigned CW = $clog2(ENABLE_CYCLES + 1);

  if (ENABLE_CYCLES < 1 || ENABLE_CYCLES > 65535) begin : g_bad_cycles
    $error("ENABLE_CYCLES must be 1 to 65535");
  end

  typedef struct packed {
    tx_state_type state;
    logic [3:0] pend;
    logic [CW-1:0] count;
    logic [15:0] hi_run;
  } rec_type;

  rec_type q;
  rec_type n;
  logic quiet;
  logic [3:0] seen;
  logic [3:0] fixed;

  // ==========================================================
  // Next state
  always_comb begin
    n = q;
    quiet = (xcvr_mode == XCVR_OFF) || (xcvr_mode == XCVR_WAKE);
    seen = {fault_supply, fault_bus_dom, fault_txd_dom, fault_tsd};
    fixed[0] = !fault_tsd;
    fixed[1] = txd || quiet; // see R09
    fixed[2] = bus_recessive || quiet; // see R10
    fixed[3] = !fault_supply; // see R11
    n.pend = (q.pend & ~fixed) | seen;
    n.hi_run = txd ? ((&q.hi_run) ? q.hi_run : q.hi_run + 16'h0001) : 16'h0000;
    case (q.state)
      TX_RUN: begin
        if (|seen) begin
          n.state = TX_FAULT; // see R06
        end
      end
      TX_FAULT: begin
        n.count = '0;
        if (n.pend == 4'h0) begin
          n.state = TX_ARM;
        end
      end
      TX_ARM: begin
        // Recessive time must be unbroken, see R12
        if (|seen) begin
          n.state = TX_FAULT;
        end else if (!txd) begin
          n.count = '0;
        end else if (q.count == CW'(ENABLE_CYCLES - 1)) begin
          n.state = TX_RUN;
        end else begin
          n.count = q.count + 1'b1;
        end
      end
      default: begin
        n.state = TX_FAULT;
      end
    endcase
    if (soft_reset) begin
      n.state = TX_RUN;
      n.pend = 4'h0;
      n.count = '0;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{state: TX_RUN, pend: 4'h0, count: '0, hi_run: 16'h0000};
    end else begin
      q <= n;
    end
  end

  assign tx_enable = (q.state == TX_RUN);

  // ==========================================================
  // Checks
  a_tx_wait_recessive: assert property ( // see R12
    @(posedge hclk) disable iff (!hresetn)
    $rose(tx_enable) && !$past(soft_reset) |-> q.hi_run >= 16'(ENABLE_CYCLES))
    else $error("transmitter enabled before enable time");
  a_tx_fault_blocks: assert property ( // see R06
    @(posedge hclk) disable iff (!hresetn)
    fault_supply && !soft_reset |=> !tx_enable)
    else $error("transmitter on during fault");
  a_tx_timeout_stays: assert property ( // see R09
    @(posedge hclk) disable iff (!hresetn)
    q.pend[1] && !txd && !quiet && !soft_reset |=> q.state != TX_RUN)
    else $error("transmit timeout left early");

endmodule

// File: bus_fault_status_register.sv
// Bus fault status register bank with AHB-Lite slave and interrupt
//
// Behaviour
// R01 - Status bits 15 to 7 always read as zero.
// R02 - LIN fault code in bits 6:5: none, thermal, transmit timeout, bus timeout.
// R03 - CAN timeout flag at bit 4 sets on timeout, else reads zero.
// R04 - System error flag at bit 3; while set selective wake stays off.
// R05 - CAN fault code in bits 2:1 with the same four codes.
// R06 - Bit 0 flags CAN supply low; transmitter off while supply is low.
// R07 - Power-on and soft reset clear all; restart keeps bits 6 to 0.
// R08 - Supply comparator enabled only in CAN normal or receive-only mode.
// R09 - Transmit timeout recovers on transmit high, wake-capable or off.
// R10 - Bus timeout recovers on recessive bus, wake-capable or off.
// R11 - Supply low recovers once supply is back above threshold.
// R12 - After any fault, transmit must stay high for enable time first.
// R13 - CAN timeout sets only in selective-wake mode, on silence rising, then holds.
// R14 - Timeout raises interrupt in stop or normal mode when its mask is one.
// R15 - System error on config error or count above 32, only when enabled.
// R16 - Timeout flag cannot be cleared before next interrupt falling edge.
// R17 - Flags and codes hold until software clears them.
`timescale 1ns/10ps
module bus_fault_status_register #(
  parameter int unsigned TX_ENABLE_CYCLES = bus_fault_pkg::TX_ENABLE_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic soft_reset,
  input wire logic restart_reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // CAN transceiver
  input wire bus_fault_pkg::xcvr_mode_type can_mode,
  input wire logic can_txd,
  input wire logic can_bus_recessive,
  input wire logic can_tsd,
  input wire logic can_txd_dom_to,
  input wire logic can_bus_dom_to,
  input wire logic can_supply_voltage_low,
  output logic can_supply_comp_enable,
  output logic can_tx_enable,
  // LIN transceiver
  input wire bus_fault_pkg::xcvr_mode_type lin_mode,
  input wire logic lin_txd,
  input wire logic lin_bus_recessive,
  input wire logic lin_tsd,
  input wire logic lin_txd_dom_to,
  input wire logic lin_bus_dom_to,
  output logic lin_tx_enable,
  // Selective wake
  input wire logic can_silence_flag,
  input wire logic selwake_config_error,
  input wire logic [5:0] selwake_error_count,
  output logic selective_wake,
  // Device mode and interrupt
  input wire logic op_mode_active,
  output logic irq,
  output logic interrupt_out_n
);
  import bus_fault_pkg::*;

  typedef struct packed {
    logic [1:0] lin_fault;
    logic can_timeout_flag;
    logic selwake_system_error;
    logic [1:0] can_fault;
    logic can_supply_low_flag;
    logic selwake_mode_bit;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic clear_block;
    logic irq_prev;
    logic silence_prev;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic rd_status;
    logic [31:0] rd_data;
  } bank_type;

  bank_type q;
  bank_type n;

  // Bus decode
  logic capture;
  logic mapped;
  logic wr_status;
  logic wr_ctrl;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic [6:0] clr;
  logic clr_can_timeout_flag;
  // Detection
  logic supply_seen;
  logic can_timeout_flag_set;
  logic selwake_system_error_set;
  logic irq_rise;
  logic [IRQ_W-1:0] ev;
  logic [1:0] lin_base;
  logic [1:0] can_base;
  logic can_tx_quiet;
  logic [1:0] tx_en;

  // ==========================================================
  // Helpers
  function automatic logic [1:0] fault_code(
    input logic tsd,
    input logic txd_to,
    input logic bus_to,
    input logic [1:0] cur
  );
    // Thermal wins when several arrive together
    if (tsd) begin
      return FAULT_TSD;
    end else if (bus_to) begin
      return FAULT_BUS_DOM;
    end else if (txd_to) begin
      return FAULT_TXD_DOM;
    end
    return cur;
  endfunction

  function automatic logic [15:0] status_word(input bank_type s);
    logic [15:0] w;
    w = STATUS_RESET; // see R01
    w[LIN_FAULT_LSB +: 2] = s.lin_fault;
    w[CAN_TIMEOUT_BIT] = s.can_timeout_flag;
    w[SELWAKE_SYSTEM_ERROR_BIT] = s.selwake_system_error;
    w[CAN_FAULT_LSB +: 2] = s.can_fault;
    w[SUPPLY_LOW_BIT] = s.can_supply_low_flag;
    return w;
  endfunction

  function automatic logic [31:0] read_word(
    input logic [7:0] idx,
    input bank_type s
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      BUS_FAULT_STATUS_IDX: w[15:0] = status_word(s);
      CTRL_IDX: w[SELWAKE_CTRL_BIT] = s.selwake_mode_bit;
      IRQ_STATUS_IDX: w[IRQ_W-1:0] = s.irq_status;
      IRQ_MASK_IDX: w[IRQ_W-1:0] = s.irq_mask;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ==========================================================
  // Bus decode
  assign capture = hsel && hready && htrans[1];
  assign mapped = (haddr[31:10] == 22'h000000);
  assign wr_status = q.wr_pend && (q.wr_idx == BUS_FAULT_STATUS_IDX);
  assign wr_ctrl = q.wr_pend && (q.wr_idx == CTRL_IDX);
  assign wr_irq_status = q.wr_pend && (q.wr_idx == IRQ_STATUS_IDX);
  assign wr_irq_mask = q.wr_pend && (q.wr_idx == IRQ_MASK_IDX);
  // Write-one-to-clear of status bits
  assign clr = wr_status ? hwdata[6:0] : 7'h00;
  assign clr_can_timeout_flag = clr[CAN_TIMEOUT_BIT] && !q.clear_block; // see R16

  // ==========================================================
  // Detection terms
  assign can_supply_comp_enable = (can_mode == XCVR_NORMAL) ||
                                  (can_mode == XCVR_RX_ONLY); // see R08
  assign supply_seen = can_supply_voltage_low && can_supply_comp_enable;
  // Edge of silence so a clear sticks while silence stays high
  assign can_timeout_flag_set = q.selwake_mode_bit && can_silence_flag &&
                     !q.silence_prev; // see R13
  assign selwake_system_error_set = q.selwake_mode_bit && (selwake_config_error ||
                      (selwake_error_count > SELWAKE_ERR_LIMIT)); // see R15
  assign irq_rise = irq && !q.irq_prev;
  assign lin_base = (|clr[LIN_FAULT_LSB +: 2]) ? FAULT_NONE : q.lin_fault;
  assign can_base = (|clr[CAN_FAULT_LSB +: 2]) ? FAULT_NONE : q.can_fault;

  // ==========================================================
  // Next state; every hardware set wins over a same-cycle clear
  always_comb begin
    n = q;
    // Fault codes latch until cleared, see R17
    n.lin_fault = fault_code(lin_tsd, lin_txd_dom_to,
                             lin_bus_dom_to, lin_base); // see R02
    n.can_fault = fault_code(can_tsd, can_txd_dom_to,
                             can_bus_dom_to, can_base); // see R05
    n.can_supply_low_flag = (q.can_supply_low_flag &&
                             !clr[SUPPLY_LOW_BIT]) || supply_seen; // see R06
    n.can_timeout_flag = (q.can_timeout_flag && !clr_can_timeout_flag) ||
                         can_timeout_flag_set; // see R03
    n.selwake_system_error = (q.selwake_system_error &&
                              !clr[SELWAKE_SYSTEM_ERROR_BIT]) || selwake_system_error_set; // see R15
    n.silence_prev = can_silence_flag;
    n.irq_prev = irq;

    // Interrupt events on fresh sets
    ev = '0;
    ev[IRQ_CAN_TIMEOUT] = can_timeout_flag_set && !q.can_timeout_flag &&
                          op_mode_active; // see R14
    ev[IRQ_SELWAKE_SYSTEM_ERROR] = n.selwake_system_error && !q.selwake_system_error;
    ev[IRQ_SUPPLY_LOW] = n.can_supply_low_flag && !q.can_supply_low_flag;
    ev[IRQ_CAN_FAULT] = (n.can_fault != q.can_fault) &&
                        (n.can_fault != FAULT_NONE);
    ev[IRQ_LIN_FAULT] = (n.lin_fault != q.lin_fault) &&
                        (n.lin_fault != FAULT_NONE);

    // Hold the timeout flag until the interrupt line falls
    if (ev[IRQ_CAN_TIMEOUT] && q.irq_mask[IRQ_CAN_TIMEOUT]) begin
      n.clear_block = 1'b1; // see R16
    end else if (irq_rise) begin
      n.clear_block = 1'b0; // see R16
    end

    // Software registers
    if (wr_ctrl) begin
      n.selwake_mode_bit = hwdata[SELWAKE_CTRL_BIT];
    end
    if (wr_irq_mask) begin
      n.irq_mask = hwdata[IRQ_W-1:0];
    end
    n.irq_status = (q.irq_status &
                    ~(wr_irq_status ? hwdata[IRQ_W-1:0] : IRQ_RESET)) | ev;

    // Address phase capture; zero wait states
    n.wr_pend = capture && hwrite && mapped;
    n.wr_idx = haddr[9:2];
    n.rd_status = capture && !hwrite && mapped &&
                  (haddr[9:2] == BUS_FAULT_STATUS_IDX);
    if (capture && !hwrite) begin
      n.rd_data = mapped ? read_word(haddr[9:2], q) : 32'h0000_0000;
    end

    // Restart keeps the flags, drops control and interrupt state
    if (restart_reset) begin
      n.selwake_mode_bit = 1'b0;
      n.irq_status = IRQ_RESET;
      n.irq_mask = IRQ_RESET;
      n.clear_block = 1'b0;
    end
    // Soft reset clears flags, codes, control and interrupt state, see R07
    if (soft_reset) begin
      n.lin_fault = FAULT_NONE;
      n.can_fault = FAULT_NONE;
      n.can_timeout_flag = 1'b0;
      n.selwake_system_error = 1'b0;
      n.can_supply_low_flag = 1'b0;
      n.selwake_mode_bit = 1'b0;
      n.irq_status = IRQ_RESET;
      n.irq_mask = IRQ_RESET;
      n.clear_block = 1'b0;
    end
  end

  // ==========================================================
  // Bank register, power-on reset clears all, see R07
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rd_data;
  assign irq = |(q.irq_status & q.irq_mask); // see R14
  assign interrupt_out_n = !irq;
  // Selective wake refused while system error stands
  assign selective_wake = q.selwake_mode_bit &&
                          !q.selwake_system_error; // see R04

  // ==========================================================
  // Transmitter recovery, one per transceiver
  assign can_tx_quiet = 1'b0;
  assign can_tx_enable = tx_en[0];
  assign lin_tx_enable = tx_en[1];
  for (genvar i = 0; i < 2; i++) begin : g_xcvr
    tx_recovery #(
      .ENABLE_CYCLES(TX_ENABLE_CYCLES)
    ) u_rec (
      .hclk(hclk),
      .hresetn(hresetn),
      .soft_reset(soft_reset),
      .fault_tsd(i == 0 ? can_tsd : lin_tsd),
      .fault_txd_dom(i == 0 ? can_txd_dom_to : lin_txd_dom_to),
      .fault_bus_dom(i == 0 ? can_bus_dom_to : lin_bus_dom_to),
      .fault_supply(i == 0 ? supply_seen : can_tx_quiet),
      .txd(i == 0 ? can_txd : lin_txd),
      .bus_recessive(i == 0 ? can_bus_recessive : lin_bus_recessive),
      .xcvr_mode(i == 0 ? can_mode : lin_mode),
      .tx_enable(tx_en[i])
    );
  end

  // ==========================================================
  // Checks
  a_reserved_read_zero: assert property ( // see R01
    @(posedge hclk) disable iff (!hresetn)
    q.rd_status |-> hrdata[31:7] == 25'h0000000)
    else $error("reserved status bits read nonzero");

  a_can_timeout_flag_needs_mode: assert property ( // see R13
    @(posedge hclk) disable iff (!hresetn)
    $rose(q.can_timeout_flag) |-> $past(q.selwake_mode_bit) &&
                                  $past(can_silence_flag))
    else $error("timeout flag set outside selective wake");

  a_can_timeout_flag_irq_raise: assert property ( // see R14
    @(posedge hclk) disable iff (!hresetn)
    $rose(q.can_timeout_flag) && $past(op_mode_active) &&
    q.irq_mask[IRQ_CAN_TIMEOUT] && !$past(soft_reset) &&
    !$past(restart_reset) |-> irq && !interrupt_out_n)
    else $error("timeout interrupt not raised");

  a_can_timeout_flag_clear_held: assert property ( // see R16
    @(posedge hclk) disable iff (!hresetn)
    q.can_timeout_flag && q.clear_block && wr_status &&
    hwdata[CAN_TIMEOUT_BIT] && !soft_reset |=> q.can_timeout_flag)
    else $error("timeout flag cleared before interrupt edge");

  a_selwake_system_error_no_wake: assert property ( // see R04
    @(posedge hclk) disable iff (!hresetn)
    q.selwake_system_error |-> !selective_wake)
    else $error("selective wake on with system error");

  a_selwake_system_error_only_enabled: assert property ( // see R15
    @(posedge hclk) disable iff (!hresetn)
    !q.selwake_mode_bit |=> !$rose(q.selwake_system_error))
    else $error("system error updated while disabled");

  a_comp_gated: assert property ( // see R08
    @(posedge hclk) disable iff (!hresetn)
    !can_supply_comp_enable |=> !$rose(q.can_supply_low_flag))
    else $error("supply flag set with comparator off");

  a_supply_holds: assert property ( // see R17
    @(posedge hclk) disable iff (!hresetn)
    q.can_supply_low_flag && !wr_status && !soft_reset
    |=> q.can_supply_low_flag)
    else $error("supply flag dropped without clear");

  a_soft_clears: assert property ( // see R07
    @(posedge hclk) disable iff (!hresetn)
    soft_reset |=> status_word(q) == STATUS_RESET)
    else $error("soft reset left status bits");

  a_can_code_tsd: assert property ( // see R05
    @(posedge hclk) disable iff (!hresetn)
    can_tsd && !soft_reset |=> q.can_fault == FAULT_TSD)
    else $error("CAN thermal code not latched");

endmodule

// File: ahb_host_model.sv
// AHB-Lite host model issuing single word transfers to the status block
`timescale 1ns/10ps
module ahb_host_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Slave answer
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // ==========================================================
  // Bus idle at time zero
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One transfer; each phase held until hready is seen high
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    // Released data lines do not keep the last value
    hwdata <= ~d;
  endtask
endmodule

// File: test_bus_fault_status_register.sv
// Self-checking bench for the bus fault status register bank
`timescale 1ns/10ps
module test_bus_fault_status_register;
  import bus_fault_pkg::*;
  // ==========================================================
  // Short enable time keeps recovery runs brief
  localparam int unsigned TXC = 4;
  localparam logic [31:0] A_CT = {22'h0, CTRL_IDX, 2'h0};
  localparam logic [31:0] A_IS = {22'h0, IRQ_STATUS_IDX, 2'h0};
  localparam logic [31:0] A_IM = {22'h0, IRQ_MASK_IDX, 2'h0};
  localparam logic [31:0] A_ST = {22'h0, BUS_FAULT_STATUS_IDX, 2'h0};
  logic hclk, hresetn, soft_reset, restart_reset, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  xcvr_mode_type can_mode, lin_mode;
  logic can_txd, can_bus_recessive, can_tsd, can_txd_dom_to, can_bus_dom_to, can_supply_voltage_low;
  logic can_supply_comp_enable, can_tx_enable, lin_txd, lin_bus_recessive, lin_tsd, lin_txd_dom_to;
  logic lin_bus_dom_to, lin_tx_enable, can_silence_flag, selwake_config_error, selective_wake;
  logic op_mode_active, irq, interrupt_out_n;
  logic [5:0] selwake_error_count;
  int miscompares = 0;
  int n_tests = 0;

  bus_fault_status_register #(.TX_ENABLE_CYCLES(TXC)) i_bus_fault_status_register (
    .hclk(hclk), .hresetn(hresetn), .soft_reset(soft_reset), .restart_reset(restart_reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .can_mode(can_mode), .can_txd(can_txd), .can_bus_recessive(can_bus_recessive), .can_tsd(can_tsd),
    .can_txd_dom_to(can_txd_dom_to), .can_bus_dom_to(can_bus_dom_to),
    .can_supply_voltage_low(can_supply_voltage_low), .can_supply_comp_enable(can_supply_comp_enable),
    .can_tx_enable(can_tx_enable), .lin_mode(lin_mode), .lin_txd(lin_txd),
    .lin_bus_recessive(lin_bus_recessive), .lin_tsd(lin_tsd), .lin_txd_dom_to(lin_txd_dom_to),
    .lin_bus_dom_to(lin_bus_dom_to), .lin_tx_enable(lin_tx_enable), .can_silence_flag(can_silence_flag),
    .selwake_config_error(selwake_config_error), .selwake_error_count(selwake_error_count),
    .selective_wake(selective_wake), .op_mode_active(op_mode_active), .irq(irq),
    .interrupt_out_n(interrupt_out_n));

  ahb_host_model i_ahb_host_model (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

  // ==========================================================
  // Clock, and reset held for 16 cycles
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_ahb_host_model.xfer(1'b1, a, d, q);
  endtask

  task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_ahb_host_model.xfer(1'b0, a, 32'h0, q);
    check(name, q, e);
  endtask

  // Fault pulse with transmit low, then transmit high and count to enable
  task automatic fault_case(input bit lin, input int k);
    int cnt;
    cnt = 0;
    lin_tsd <= lin && k == 1;
    lin_txd_dom_to <= lin && k == 2;
    lin_bus_dom_to <= lin && k == 3;
    can_tsd <= !lin && k == 1;
    can_txd_dom_to <= !lin && k == 2;
    can_bus_dom_to <= !lin && k == 3;
    can_txd <= lin;
    lin_txd <= !lin;
    tick(1);
    {lin_tsd, lin_txd_dom_to, lin_bus_dom_to, can_tsd, can_txd_dom_to, can_bus_dom_to} <= 6'h0;
    tick(10);
    check("tx_enable held", {31'h0, lin ? lin_tx_enable : can_tx_enable}, 32'h0);
    // Controller keeps transmit high through the enable time
    can_txd <= 1'b1;
    lin_txd <= 1'b1;
    while ((lin ? lin_tx_enable : can_tx_enable) !== 1'b1 && cnt < 50) begin
      tick(1);
      cnt++;
    end
    check("recovery time", {31'h0, cnt >= TXC && cnt <= TXC + 4}, 32'h1);
    rdchk("fault code", A_ST, 32'(k) << (lin ? LIN_FAULT_LSB : CAN_FAULT_LSB));
    wr(A_ST, lin ? 32'h60 : 32'h6);
    rdchk("code cleared", A_ST, 32'h0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    hresetn = 1'b0;
    {soft_reset, restart_reset, can_tsd, can_txd_dom_to, can_bus_dom_to, can_supply_voltage_low} = 6'h0;
    {lin_tsd, lin_txd_dom_to, lin_bus_dom_to, can_silence_flag, selwake_config_error, op_mode_active} = 6'h0;
    {can_txd, can_bus_recessive, lin_txd, lin_bus_recessive} = 4'hf;
    can_mode = XCVR_NORMAL;
    lin_mode = XCVR_NORMAL;
    selwake_error_count = 6'h0;
    tick(16);
    hresetn <= 1'b1;
    rdchk("status reset", A_ST, 32'h0);
    rdchk("mask reset", A_IM, 32'h0);
    rdchk("unmapped", 32'h400, 32'h0);
    for (int k = 1; k < 4; k++) begin
      fault_case(1'b0, k);
      fault_case(1'b1, k);
    end
    // Comparator enable across all modes, supply fault ignored when off
    for (int m = 0; m < 4; m++) begin
      can_mode <= xcvr_mode_type'(m);
      tick(2);
      check("comp enable", {31'h0, can_supply_comp_enable}, {31'h0, m >= 2});
    end
    can_mode <= XCVR_WAKE;
    can_supply_voltage_low <= 1'b1;
    tick(3);
    rdchk("supply off mode", A_ST, 32'h0);
    can_mode <= XCVR_NORMAL;
    tick(3);
    check("tx off supply", {31'h0, can_tx_enable}, 32'h0);
    can_supply_voltage_low <= 1'b0;
    tick(TXC + 6);
    check("tx back supply", {31'h0, can_tx_enable}, 32'h1);
    rdchk("supply held", A_ST, 32'h1);
    wr(A_ST, 32'h1);
    // Timeout flag needs selective-wake mode
    op_mode_active <= 1'b1;
    wr(A_IS, 32'h1f);
    wr(A_IM, 32'h5);
    can_silence_flag <= 1'b1;
    tick(2);
    can_silence_flag <= 1'b0;
    rdchk("timeout no mode", A_ST, 32'h0);
    check("irq idle", {31'h0, irq}, 32'h0);
    wr(A_CT, 32'h1);
    can_silence_flag <= 1'b1;
    tick(2);
    check("irq on timeout", {31'h0, interrupt_out_n}, 32'h0);
    can_silence_flag <= 1'b0;
    rdchk("timeout held", A_ST, 32'h10);
    // Reporting edge passed, clear lands
    wr(A_ST, 32'h10);
    rdchk("clear after edge", A_ST, 32'h0);
    // New flag, line already low: clear ignored
    can_silence_flag <= 1'b1;
    tick(2);
    can_silence_flag <= 1'b0;
    wr(A_ST, 32'h10);
    rdchk("clear blocked", A_ST, 32'h10);
    wr(A_IS, 32'h1f);
    tick(2);
    check("irq cleared", {31'h0, interrupt_out_n}, 32'h1);
    // A fresh interrupt edge releases the clear block
    can_supply_voltage_low <= 1'b1;
    tick(2);
    can_supply_voltage_low <= 1'b0;
    check("irq supply", {31'h0, interrupt_out_n}, 32'h0);
    wr(A_ST, 32'h11);
    rdchk("clear released", A_ST, 32'h0);
    wr(A_IS, 32'h5);
    wr(A_IM, 32'h0);
    can_supply_voltage_low <= 1'b1;
    tick(2);
    can_supply_voltage_low <= 1'b0;
    check("irq masked", {31'h0, interrupt_out_n}, 32'h1);
    rdchk("irq status", A_IS, 32'h4);
    wr(A_IS, 32'h4);
    wr(A_ST, 32'h1);
    tick(TXC + 6);
    // Error count boundary and system error blocking selective wake
    selwake_error_count <= 6'd32;
    tick(3);
    rdchk("count 32", A_ST, 32'h0);
    check("wake on", {31'h0, selective_wake}, 32'h1);
    selwake_error_count <= 6'd33;
    tick(3);
    selwake_error_count <= 6'd0;
    rdchk("count 33", A_ST, 32'h8);
    check("wake refused", {31'h0, selective_wake}, 32'h0);
    wr(A_ST, 32'h8);
    wr(A_CT, 32'h0);
    selwake_config_error <= 1'b1;
    tick(3);
    selwake_config_error <= 1'b0;
    rdchk("config no mode", A_ST, 32'h0);
    // Restart keeps low bits, soft reset clears them
    can_bus_dom_to <= 1'b1;
    tick(1);
    can_bus_dom_to <= 1'b0;
    wr(A_CT, 32'h1);
    restart_reset <= 1'b1;
    tick(1);
    restart_reset <= 1'b0;
    rdchk("restart keeps", A_ST, 32'h6);
    rdchk("restart ctrl", A_CT, 32'h0);
    soft_reset <= 1'b1;
    tick(1);
    soft_reset <= 1'b0;
    rdchk("soft clears", A_ST, 32'h0);
    conclude();
  end

  // Watchdog well beyond the expected run length
  initial begin
    tick(30000);
    miscompares++;
    conclude();
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
endmodule
